//--- src/pspp_pkg.sv
/*
  Shared constants and carriers for the pump pressure setpoint panel.
  Assumes a 25 MHz core clock; all times run off a 1 ms tick.
*/
`default_nettype none
package pspp_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS  = 40;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_S    = 1_000_000_000 / TICK_PERIOD_NS;

  // Operator timing, in ticks
  localparam int HOLD_TIME_S      = 2;
  localparam int HOLD_TICKS       = HOLD_TIME_S * TICKS_PER_S;
  localparam int SHOW_TIME_S      = 6;
  localparam int SHOW_TICKS       = SHOW_TIME_S * TICKS_PER_S;
  localparam int DEBOUNCE_TIME_MS = 10;
  localparam int DEBOUNCE_TICKS   = DEBOUNCE_TIME_MS * TICKS_PER_S / 1000;
  localparam int REPEAT_TIME_MS   = 250;
  localparam int REPEAT_TICKS     = REPEAT_TIME_MS * TICKS_PER_S / 1000;
  localparam int CTRL_TIME_MS     = 10;
  localparam int CTRL_TICKS       = CTRL_TIME_MS * TICKS_PER_S / 1000;
  localparam int BLINK_TIME_MS    = 250;
  localparam int BLINK_TICKS      = BLINK_TIME_MS * TICKS_PER_S / 1000;

  // Ranges and step sizes
  localparam logic [11:0] PRESS_MIN   = 12'h02d;
  localparam logic [11:0] PRESS_MAX   = 12'h12c;
  localparam logic [11:0] SPEED_MIN   = 12'h2bc;
  localparam logic [11:0] SPEED_MAX   = 12'h960;
  localparam logic [11:0] HIIDLE_MIN  = 12'h320;
  localparam logic [11:0] HIIDLE_MAX  = 12'h960;
  localparam logic [11:0] DISP_MAX    = 12'h258;
  localparam logic [11:0] VAC_MAX     = 12'h01e;
  localparam logic [11:0] P_STEP_1    = 12'h001;
  localparam logic [11:0] P_STEP_2    = 12'h005;
  localparam logic [11:0] P_STEP_3    = 12'h00a;
  localparam logic [11:0] S_STEP_1    = 12'h00a;
  localparam logic [11:0] S_STEP_2    = 12'h032;
  localparam logic [11:0] S_STEP_3    = 12'h064;
  localparam logic [11:0] GOV_STEP    = 12'h005;
  localparam logic [2:0]  FAST_AFTER  = 3'h4;
  localparam logic [7:0]  VAC_SCALE   = 8'h82;
  localparam int          BAR_SEGS    = 16;

  // Button bit positions in the input carrier
  localparam int B_HIIDLE = 0;
  localparam int B_MODE   = 1;
  localparam int B_IDLE   = 2;
  localparam int B_PRESET = 3;
  localparam int B_DEC    = 4;
  localparam int B_INC    = 5;

  typedef enum logic {
    MODE_PRESSURE = 1'b0,
    MODE_SPEED    = 1'b1
  } pspp_mode_e;

  typedef enum logic [1:0] {
    LOW_INTAKE_PSI = 2'b00,
    LOW_INTAKE_VAC = 2'b01,
    LOW_SETTING    = 2'b10,
    LOW_IDLE_MSG   = 2'b11
  } pspp_lower_e;

  typedef struct packed {
    logic inc;
    logic dec;
    logic preset;
    logic idle;
    logic mode;
    logic hiIdle;
  } pspp_buttons_s;

  typedef struct packed {
    pspp_lower_e kind;
    logic [11:0] value;
    logic        flash;
    logic        lit;
  } pspp_lower_s;

  typedef struct packed {
    logic pressure;
    logic speed;
    logic idle;
  } pspp_lamps_s;

endpackage

`default_nettype wire

//--- src/pspp_panel.sv
/*
  Pump pressure setpoint panel: button handling, setpoint keeping,
  displays, bar graph and engine speed command.
  Assumes buttons arrive raw from pins, pressure samples come from a
  converter on core_clk, and the speed command feeds an engine controller.
*/
// Functional notes
// - After reset select pressure mode and light the amber pressure lamp.
// - Light the red idle lamp while the unit holds the engine at idle.
// - Increase and decrease adjust the pressure setpoint within 45 to 300 psi.
// - A short press steps the setpoint by exactly 1 psi.
// - Held over 2 s, repeat steps of 5 psi, then 10 psi.
// - While adjusting, lower window shows the flashing setpoint, not intake.
// - Setpoint keeps flashing 6 s after release, then intake returns.
// - Idle drops engine to idle and flashes an idle message for 6 s.
// - Preset loads stored setpoint, flashes it and raises engine speed.
// - After preset, adjust and idle buttons keep working as usual.
// - Bar graph shows pressure setpoint, or speed setpoint in speed mode.
// - Upper window shows discharge 0 to 600 psi in 1 psi steps.
// - First sample after reset becomes the offset so discharge starts at 0.
// - Lower window shows intake from -30 inHg to 600 psi.
// - Below 0 psig show vacuum in whole inHg, else whole psi.
// - Pressure mode trims speed command to hold discharge at setpoint.
// - Speed mode holds the speed command at the selected setting.
// - Mode change takes over present values, so no step occurs.
// - Remote high idle speed is configurable from 800 to 2400 RPM.
// - Each mode press toggles pressure and speed mode and its lamps.
`timescale 1ns/1ns
`default_nettype none

module pspp_panel #(
  parameter int TICK_CYCLES = pspp_pkg::TICK_CYCLES,
  parameter logic [11:0] PRESET_PSI = 12'h096,
  parameter logic [11:0] PRESET_RPM = 12'h4b0
) (
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire pspp_pkg::pspp_buttons_s btnPins,
  input  wire logic [11:0]           highIdleRpm,
  input  wire logic                  sampleValid,
  input  wire logic [14:0]           dischargeRaw,
  input  wire logic signed [15:0]    intakeRaw,
  output logic [11:0]                speedCmd,
  output logic [11:0]                dischargePsi,
  output pspp_pkg::pspp_lower_s      lower,
  output logic [15:0]                bar,
  output pspp_pkg::pspp_lamps_s      lamps
);

  typedef struct packed {
    logic [5:0]       sync1;
    logic [5:0]       sync2;
    logic [5:0]       stable;
    logic [5:0]       prev;
    logic [5:0][3:0]  debCnt;
    logic [14:0]      tickCnt;
    logic [11:0]      holdMs;
    logic [7:0]       repMs;
    logic [2:0]       fastCnt;
    logic [12:0]      showMs;
    logic [12:0]      idleMs;
    logic [7:0]       blinkMs;
    logic             blinkPhase;
    logic [3:0]       ctrlMs;
    pspp_pkg::pspp_mode_e mode;
    logic             active;
    logic             calDone;
    logic [14:0]      offset;
    logic [11:0]      pressSet;
    logic [11:0]      speedSet;
    logic [11:0]      speedCmd;
    logic [11:0]      upper;
    logic             intakeVac;
    logic [11:0]      intakeVal;
    pspp_pkg::pspp_lower_s lower;
    logic [15:0]      bar;
    pspp_pkg::pspp_lamps_s lamps;
  } pspp_state_s;

  pspp_state_s st;
  pspp_state_s next_st;

  logic        msTick;
  logic        ctrlTick;
  logic [5:0]  rise;
  logic        incHeld;
  logic        decHeld;
  logic        adjHeld;
  logic        stepNow;
  logic [1:0]  stepLvl;
  logic [11:0] stepSz;
  logic [11:0] idleTarget;
  logic [14:0] calDiff;
  logic [15:0] vacMag;
  logic [23:0] vacProd;
  logic [15:0] barP;
  logic [15:0] barS;

  // Saturating step of a value toward hi or lo
  function automatic logic [11:0] bump(input logic [11:0] v, input logic up,
                                       input logic [11:0] sz, input logic [11:0] lo,
                                       input logic [11:0] hi);
    logic [11:0] r;
    r = v;
    if (up) begin
      r = (v + sz > hi) ? hi : v + sz;
    end else begin
      r = (v < lo + sz) ? lo : v - sz;
    end
    return r;
  endfunction

  // Clamp a value into a range
  function automatic logic [11:0] clampVal(input logic [11:0] v, input logic [11:0] lo,
                                           input logic [11:0] hi);
    logic [11:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // Bar graph thresholds, two comparators per segment, one per setpoint
  genvar gi;
  generate
    for (gi = 0; gi < pspp_pkg::BAR_SEGS; gi++) begin : gBar
      localparam int PSPAN = int'(pspp_pkg::PRESS_MAX - pspp_pkg::PRESS_MIN);
      localparam int SSPAN = int'(pspp_pkg::SPEED_MAX - pspp_pkg::SPEED_MIN);
      localparam logic [11:0] PTHR = 12'(int'(pspp_pkg::PRESS_MIN) + gi * PSPAN / pspp_pkg::BAR_SEGS);
      localparam logic [11:0] STHR = 12'(int'(pspp_pkg::SPEED_MIN) + gi * SSPAN / pspp_pkg::BAR_SEGS);
      assign barP[gi] = st.pressSet >= PTHR;
      assign barS[gi] = st.speedSet >= STHR;
    end
  endgenerate

  // Next state
  always_comb begin
    next_st = st;

    // Millisecond time base
    msTick = st.tickCnt == 15'(TICK_CYCLES - 1);
    next_st.tickCnt = msTick ? 15'h0 : st.tickCnt + 15'h1;

    // Two-stage synchroniser, then per-button debounce
    next_st.sync1 = btnPins;
    next_st.sync2 = st.sync1;
    for (int i = 0; i < 6; i++) begin
      if (st.sync2[i] == st.stable[i]) begin
        next_st.debCnt[i] = 4'h0;
      end else if (msTick) begin
        if (st.debCnt[i] == 4'(pspp_pkg::DEBOUNCE_TICKS - 1)) begin
          next_st.stable[i] = st.sync2[i];
          next_st.debCnt[i] = 4'h0;
        end else begin
          next_st.debCnt[i] = st.debCnt[i] + 4'h1;
        end
      end
    end
    next_st.prev = st.stable;
    rise = st.stable & ~st.prev;

    // Adjust buttons; both held at once is ignored
    incHeld = st.stable[pspp_pkg::B_INC] & ~st.stable[pspp_pkg::B_DEC];
    decHeld = st.stable[pspp_pkg::B_DEC] & ~st.stable[pspp_pkg::B_INC];
    adjHeld = incHeld | decHeld;
    stepNow = (rise[pspp_pkg::B_INC] & incHeld) | (rise[pspp_pkg::B_DEC] & decHeld);
    stepLvl = 2'h0;

    // Hold timer and repeat stepping
    if (!adjHeld) begin
      next_st.holdMs = 12'h0;
      next_st.repMs = 8'h0;
      next_st.fastCnt = 3'h0;
    end else if (msTick) begin
      if (st.holdMs != 12'(pspp_pkg::HOLD_TICKS)) begin
        next_st.holdMs = st.holdMs + 12'h1;
      end else if (st.repMs == 8'(pspp_pkg::REPEAT_TICKS - 1)) begin
        next_st.repMs = 8'h0;
        stepNow = 1'b1;
        stepLvl = (st.fastCnt == pspp_pkg::FAST_AFTER) ? 2'h2 : 2'h1;
        if (st.fastCnt != pspp_pkg::FAST_AFTER) begin
          next_st.fastCnt = st.fastCnt + 3'h1;
        end
      end else begin
        next_st.repMs = st.repMs + 8'h1;
      end
    end

    // Step size for the active mode
    case ({st.mode, stepLvl})
      3'b000:  stepSz = pspp_pkg::P_STEP_1;
      3'b001:  stepSz = pspp_pkg::P_STEP_2;
      3'b010:  stepSz = pspp_pkg::P_STEP_3;
      3'b100:  stepSz = pspp_pkg::S_STEP_1;
      3'b101:  stepSz = pspp_pkg::S_STEP_2;
      3'b110:  stepSz = pspp_pkg::S_STEP_3;
      default: stepSz = 12'h0;
    endcase

    // Apply a step to the active setpoint, saturating at the limits
    if (stepNow) begin
      next_st.active = 1'b1;
      if (st.mode == pspp_pkg::MODE_PRESSURE) begin
        next_st.pressSet = bump(st.pressSet, incHeld, stepSz,
                                pspp_pkg::PRESS_MIN, pspp_pkg::PRESS_MAX);
      end else begin
        next_st.speedSet = bump(st.speedSet, incHeld, stepSz,
                                pspp_pkg::SPEED_MIN, pspp_pkg::SPEED_MAX);
      end
    end

    // Preset loads the stored setting and engages the governor
    if (rise[pspp_pkg::B_PRESET]) begin
      next_st.active = 1'b1;
      if (st.mode == pspp_pkg::MODE_PRESSURE) begin
        next_st.pressSet = clampVal(PRESET_PSI, pspp_pkg::PRESS_MIN, pspp_pkg::PRESS_MAX);
      end else begin
        next_st.speedSet = clampVal(PRESET_RPM, pspp_pkg::SPEED_MIN, pspp_pkg::SPEED_MAX);
      end
    end

    // Mode toggle takes over the present values
    if (rise[pspp_pkg::B_MODE]) begin
      if (st.mode == pspp_pkg::MODE_PRESSURE) begin
        next_st.mode = pspp_pkg::MODE_SPEED;
        next_st.speedSet = clampVal(st.speedCmd, pspp_pkg::SPEED_MIN, pspp_pkg::SPEED_MAX);
      end else begin
        next_st.mode = pspp_pkg::MODE_PRESSURE;
        next_st.pressSet = clampVal(st.upper, pspp_pkg::PRESS_MIN, pspp_pkg::PRESS_MAX);
      end
    end

    // Setting display timer: reloads while held, runs out after release
    if (adjHeld || rise[pspp_pkg::B_PRESET]) begin
      next_st.showMs = 13'(pspp_pkg::SHOW_TICKS);
      next_st.idleMs = 13'h0;
    end else if (msTick && st.showMs != 13'h0) begin
      next_st.showMs = st.showMs - 13'h1;
    end
    if (msTick && st.idleMs != 13'h0 && !adjHeld) begin
      next_st.idleMs = st.idleMs - 13'h1;
    end

    // Idle button wins over adjust and preset presses in the same cycle; a mode press still toggles
    if (rise[pspp_pkg::B_IDLE]) begin
      next_st.active = 1'b0;
      next_st.idleMs = 13'(pspp_pkg::SHOW_TICKS);
      next_st.showMs = 13'h0;
    end

    // Idle target, raised by the remote high idle input
    idleTarget = pspp_pkg::SPEED_MIN;
    if (st.stable[pspp_pkg::B_HIIDLE]) begin
      idleTarget = clampVal(highIdleRpm, pspp_pkg::HIIDLE_MIN, pspp_pkg::HIIDLE_MAX);
    end

    // Governor
    next_st.ctrlMs = st.ctrlMs;
    ctrlTick = 1'b0;
    if (msTick) begin
      ctrlTick = st.ctrlMs == 4'(pspp_pkg::CTRL_TICKS - 1);
      next_st.ctrlMs = ctrlTick ? 4'h0 : st.ctrlMs + 4'h1;
    end
    if (!st.active) begin
      next_st.speedCmd = idleTarget;
    end else if (ctrlTick && st.mode == pspp_pkg::MODE_PRESSURE) begin
      if (st.upper != st.pressSet) begin
        next_st.speedCmd = bump(st.speedCmd, st.upper < st.pressSet, pspp_pkg::GOV_STEP,
                                pspp_pkg::SPEED_MIN, pspp_pkg::SPEED_MAX);
      end
    end else if (ctrlTick) begin
      if (st.speedCmd < st.speedSet) begin
        next_st.speedCmd = bump(st.speedCmd, 1'b1, pspp_pkg::GOV_STEP,
                                pspp_pkg::SPEED_MIN, st.speedSet);
      end else begin
        next_st.speedCmd = bump(st.speedCmd, 1'b0, pspp_pkg::GOV_STEP,
                                st.speedSet, pspp_pkg::SPEED_MAX);
      end
    end

    // Discharge: first sample is the zero offset
    calDiff = (dischargeRaw > st.offset) ? dischargeRaw - st.offset : 15'h0;
    vacMag = 16'(-intakeRaw);
    vacProd = vacMag * pspp_pkg::VAC_SCALE;
    if (sampleValid) begin
      if (!st.calDone) begin
        next_st.calDone = 1'b1;
        next_st.offset = dischargeRaw;
        next_st.upper = 12'h0;
      end else begin
        next_st.upper = clampVal({1'b0, calDiff[14:4]}, 12'h0, pspp_pkg::DISP_MAX);
      end
      // Intake: vacuum in inHg below zero, psi at or above
      next_st.intakeVac = intakeRaw[15];
      if (intakeRaw[15]) begin
        next_st.intakeVal = clampVal(vacProd[21:10], 12'h0, pspp_pkg::VAC_MAX);
      end else begin
        next_st.intakeVal = clampVal({1'b0, intakeRaw[14:4]}, 12'h0, pspp_pkg::DISP_MAX);
      end
    end

    // Blink phase for flashing readouts
    if (msTick) begin
      if (st.blinkMs == 8'(pspp_pkg::BLINK_TICKS - 1)) begin
        next_st.blinkMs = 8'h0;
        next_st.blinkPhase = ~st.blinkPhase;
      end else begin
        next_st.blinkMs = st.blinkMs + 8'h1;
      end
    end

    // Lower window selection
    if (next_st.idleMs != 13'h0) begin
      next_st.lower.kind = pspp_pkg::LOW_IDLE_MSG;
      next_st.lower.value = 12'h0;
      next_st.lower.flash = 1'b1;
    end else if (next_st.showMs != 13'h0) begin
      next_st.lower.kind = pspp_pkg::LOW_SETTING;
      next_st.lower.value = (next_st.mode == pspp_pkg::MODE_PRESSURE) ?
                            next_st.pressSet : next_st.speedSet;
      next_st.lower.flash = 1'b1;
    end else begin
      next_st.lower.kind = next_st.intakeVac ? pspp_pkg::LOW_INTAKE_VAC
                                             : pspp_pkg::LOW_INTAKE_PSI;
      next_st.lower.value = next_st.intakeVal;
      next_st.lower.flash = 1'b0;
    end
    next_st.lower.lit = ~next_st.lower.flash | next_st.blinkPhase;

    // Bar graph and lamps
    next_st.bar = (st.mode == pspp_pkg::MODE_SPEED) ? barS : barP;
    next_st.lamps.pressure = next_st.mode == pspp_pkg::MODE_PRESSURE;
    next_st.lamps.speed = next_st.mode == pspp_pkg::MODE_SPEED;
    next_st.lamps.idle = ~next_st.active & ~st.stable[pspp_pkg::B_HIIDLE];

    // Synchronous reset
    if (srst) begin
      next_st = '0;
      next_st.mode = pspp_pkg::MODE_PRESSURE;
      next_st.pressSet = pspp_pkg::PRESS_MIN;
      next_st.speedSet = pspp_pkg::SPEED_MIN;
      next_st.speedCmd = pspp_pkg::SPEED_MIN;
      next_st.lamps.pressure = 1'b1;
      next_st.lamps.idle = 1'b1;
      next_st.lower.lit = 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  // Outputs straight from state
  assign speedCmd = st.speedCmd;
  assign dischargePsi = st.upper;
  assign lower = st.lower;
  assign bar = st.bar;
  assign lamps = st.lamps;

endmodule

`default_nettype wire

//--- tb/pspp_panel_assertions.sv
/*
  Checker for the setpoint panel outputs.
  Assumes it is bound to pspp_panel and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module pspp_panel_assertions #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic                    core_clk,
  input wire logic                    srst,
  input wire pspp_pkg::pspp_buttons_s btnPins,
  input wire logic [11:0]             speedCmd,
  input wire logic [11:0]             dischargePsi,
  input wire pspp_pkg::pspp_lower_s   lower,
  input wire logic [15:0]             bar,
  input wire pspp_pkg::pspp_lamps_s   lamps
);
  localparam int SHOW_CYC = pspp_pkg::SHOW_TICKS * TICK_CYCLES;
  int quietCnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Cycles since both adjust pins went low, saturating
  always_ff @(posedge core_clk) begin
    if (srst || btnPins.inc || btnPins.dec) begin
      quietCnt <= 0;
    end else if (quietCnt < SHOW_CYC) begin
      quietCnt <= quietCnt + 1;
    end
  end
  // Setting display gives way to intake
  sequence s_setting_left;
    $past(lower.kind) == pspp_pkg::LOW_SETTING ##0 !lower.kind[1];
  endsequence
  // Control mode flips
  sequence s_mode_flip;
    $changed(lamps.speed);
  endsequence
  a_reset_state: assert property (disable iff (1'b0) srst |=> lamps.pressure && !lamps.speed
    && lamps.idle && speedCmd == 12'h2bc && bar == 16'h0000) else $error("bad state after reset");
  a_mode_lamps: assert property (lamps.pressure != lamps.speed)
    else $error("mode lamps not exclusive");
  a_idle_speed: assert property ($past(lamps.idle) && lamps.idle |-> speedCmd == 12'h2bc)
    else $error("idle lamp without idle speed");
  a_disch_max: assert property (dischargePsi <= pspp_pkg::DISP_MAX)
    else $error("discharge above full scale");
  a_vac_max: assert property (lower.kind == pspp_pkg::LOW_INTAKE_VAC |-> lower.value <= pspp_pkg::VAC_MAX)
    else $error("vacuum above full scale");
  a_set_range: assert property (lower.kind == pspp_pkg::LOW_SETTING && lamps.pressure
    && $past(lamps.pressure) |-> lower.value inside {[pspp_pkg::PRESS_MIN:pspp_pkg::PRESS_MAX]})
    else $error("pressure setting out of range");
  a_flash_kind: assert property (lower.flash == lower.kind[1])
    else $error("flash does not match display kind");
  a_lit_steady: assert property (!lower.flash |-> lower.lit)
    else $error("steady readout blanked");
  a_mode_nostep: assert property (s_mode_flip |-> 12'(speedCmd - $past(speedCmd) + 12'h005) <= 12'h00a)
    else $error("speed step at mode change");
  a_bar_thermo: assert property (((bar + 16'h0001) & bar) == 16'h0000)
    else $error("bar graph not a thermometer");
  a_show_hold: assert property (s_setting_left |-> quietCnt == SHOW_CYC)
    else $error("setting left display too early");
endmodule
bind pspp_panel pspp_panel_assertions #(.TICK_CYCLES(TICK_CYCLES)) pspp_panel_assertions_inst (
  .core_clk(core_clk), .srst(srst), .btnPins(btnPins), .speedCmd(speedCmd),
  .dischargePsi(dischargePsi), .lower(lower), .bar(bar), .lamps(lamps));
`default_nettype wire

//--- tb/pspp_far_side.sv
/*
  Pump and transducer model: discharge follows engine speed, samples every 16 cycles.
  Assumes the bench sets extra head and intake pressure.
*/
`timescale 1ns/1ns
`default_nettype none
module pspp_far_side #(
  parameter logic [14:0] ZERO_RAW = 15'h0050
) (
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic [11:0]        speedCmd,
  input  wire logic [14:0]        extraRaw,
  input  wire logic signed [15:0] intakeSet,
  output logic                    sampleValid,
  output logic [14:0]             dischargeRaw,
  output logic signed [15:0]      intakeRaw
);
  logic [3:0]         phase = 4'h0;
  logic               valid = 1'h0;
  logic [14:0]        dRaw  = 15'h0000;
  logic signed [15:0] iRaw  = 16'h0000;
  logic [14:0]        pumpRaw;
  // Pump head rises a quarter psi per RPM above idle
  assign pumpRaw = (speedCmd > 12'h2bc) ? 15'((speedCmd - 12'h2bc) * 4) : 15'h0000;
  // Data valid only with the strobe, toggling garbage between
  always_ff @(posedge core_clk) begin
    phase <= srst ? 4'h0 : phase + 4'h1;
    valid <= !srst && phase == 4'hf;
    if (!srst && phase == 4'hf) begin
      dRaw <= ZERO_RAW + pumpRaw + extraRaw;
      iRaw <= intakeSet;
    end else begin
      dRaw <= ~dRaw;
      iRaw <= ~iRaw;
    end
  end
  assign sampleValid  = valid;
  assign dischargeRaw = dRaw;
  assign intakeRaw    = iRaw;
endmodule
`default_nettype wire

//--- tb/pspp_panel_tb.sv
/*
  Testbench for the setpoint panel driving the far-side model.
  Assumes a 4-cycle tick so that seconds fit a short run.
*/
`timescale 1ns/1ns
`default_nettype none
module pspp_panel_tb;
  localparam int SEC = 4000;
  logic                    core_clk;
  logic                    srst;
  pspp_pkg::pspp_buttons_s btnPins;
  logic [11:0]             highIdleRpm, speedCmd, dischargePsi;
  logic                    sampleValid;
  logic [14:0]             dischargeRaw, extraRaw;
  logic signed [15:0]      intakeRaw, intakeSet;
  pspp_pkg::pspp_lower_s   lower;
  logic [15:0]             bar;
  pspp_pkg::pspp_lamps_s   lamps;
  int                      num_errors = 0;
  int                      checks_done = 0;

  pspp_panel #(.TICK_CYCLES(4)) pspp_panel_inst (.core_clk(core_clk), .srst(srst), .btnPins(btnPins),
    .highIdleRpm(highIdleRpm), .sampleValid(sampleValid), .dischargeRaw(dischargeRaw),
    .intakeRaw(intakeRaw), .speedCmd(speedCmd), .dischargePsi(dischargePsi), .lower(lower),
    .bar(bar), .lamps(lamps));
  pspp_far_side pspp_far_side_inst (.core_clk(core_clk), .srst(srst), .speedCmd(speedCmd),
    .extraRaw(extraRaw), .intakeSet(intakeSet), .sampleValid(sampleValid),
    .dischargeRaw(dischargeRaw), .intakeRaw(intakeRaw));

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A wait that used its whole bound ends the run
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      $display("[FAIL] wait bound expected below %0d seen %0d", lim, n);
      end_of_test();
    end
  endtask
  // Press long enough to pass debounce, release, settle
  task automatic press(input int idx);
    btnPins[idx] = 1'h1;
    cyc(200);
    btnPins[idx] = 1'h0;
    cyc(100);
  endtask

  task automatic t_reset;
    chk("pressure lamp", 1'h1, lamps.pressure);
    chk("speed lamp", 1'h0, lamps.speed);
    chk("idle lamp", 1'h1, lamps.idle);
    cyc(40);
    chk("discharge zero", 12'h000, dischargePsi);
  endtask
  task automatic t_displays;
    logic [14:0] dRaw[3] = '{15'h07b0, 15'h2bc0, 15'h0000};
    logic [15:0] iRaw[3] = '{16'h0190, 16'hff60, 16'hfec0};
    logic [11:0] dExp[3] = '{12'h07b, 12'h258, 12'h000};
    logic [11:0] vExp[3] = '{12'h019, 12'h014, 12'h01e};
    logic [1:0]  kExp[3] = '{2'h0, 2'h1, 2'h1};
    for (int i = 0; i < 3; i++) begin
      extraRaw = dRaw[i];
      intakeSet = iRaw[i];
      cyc(40);
      chk("discharge", dExp[i], dischargePsi);
      chk("intake kind", kExp[i], lower.kind);
      chk("intake value", vExp[i], lower.value);
    end
    intakeSet = 16'h0190;
    cyc(40);
  endtask
  task automatic t_adjust;
    logic lit;
    press(pspp_pkg::B_INC);
    chk("setting kind", 2'h2, lower.kind);
    chk("inc step", 12'h02e, lower.value);
    press(pspp_pkg::B_DEC);
    press(pspp_pkg::B_DEC);
    chk("dec floor", 12'h02d, lower.value);
    lit = lower.lit;
    cyc(1000);
    chk("setting blinks", !lit, lower.lit);
    cyc(6 * SEC - 1300);
    chk("still shown", 2'h2, lower.kind);
    cyc(400);
    chk("intake back", 2'h0, lower.kind);
  endtask
  task automatic t_hold;
    logic [11:0] stepExp[6] = '{12'h005, 12'h005, 12'h005, 12'h005, 12'h00a, 12'h00a};
    logic [11:0] last;
    int n;
    btnPins.inc = 1'h1;
    cyc(7800);
    last = lower.value;
    chk("no repeat yet", 12'h02e, last);
    for (int k = 0; k < 6; k++) begin
      for (n = 0; n < 2000 && lower.value === last; n++) cyc(1);
      bound(n, 2000);
      chk("repeat step", stepExp[k], lower.value - last);
      last = lower.value;
    end
    btnPins.inc = 1'h0;
    cyc(100);
    chk("bar graph", 16'h0007, bar);
  endtask
  task automatic t_preset;
    int n;
    press(pspp_pkg::B_PRESET);
    chk("preset shown", 12'h096, lower.value);
    chk("idle lamp off", 1'h0, lamps.idle);
    for (n = 0; n < 12000 && dischargePsi !== 12'h096; n++) cyc(1);
    bound(n, 12000);
    chk("governed", 12'h096, dischargePsi);
    press(pspp_pkg::B_INC);
    chk("adjust after preset", 12'h097, lower.value);
  endtask
  task automatic t_mode;
    logic [11:0] held;
    press(pspp_pkg::B_MODE);
    chk("speed mode", 1'h1, lamps.speed);
    held = speedCmd;
    extraRaw = 15'h0320;
    cyc(800);
    chk("speed held", held, speedCmd);
    press(pspp_pkg::B_INC);
    chk("speed step", held + 12'h00a, lower.value);
    chk("speed follows", held + 12'h00a, speedCmd);
    chk("speed bar", 16'h003f, bar);
    press(pspp_pkg::B_MODE);
    chk("pressure mode", 1'h1, lamps.pressure);
    extraRaw = 15'h0000;
  endtask
  task automatic t_idle;
    press(pspp_pkg::B_IDLE);
    chk("idle msg", 2'h3, lower.kind);
    chk("idle speed", 12'h2bc, speedCmd);
    chk("idle lamp", 1'h1, lamps.idle);
    cyc(6 * SEC - 400);
    chk("idle msg kept", 2'h3, lower.kind);
    cyc(400);
    chk("idle msg gone", 2'h0, lower.kind);
    btnPins.hiIdle = 1'h1;
    cyc(100);
    chk("high idle speed", 12'h5dc, speedCmd);
    highIdleRpm = 12'h1f4;
    cyc(2);
    chk("high idle floor", 12'h320, speedCmd);
    chk("idle lamp high", 1'h0, lamps.idle);
    btnPins.hiIdle = 1'h0;
    cyc(100);
    chk("idle speed back", 12'h2bc, speedCmd);
  endtask

  // Free-running core clock
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  // Main sequence
  initial begin
    srst = 1'h1;
    btnPins = '0;
    highIdleRpm = 12'h5dc;
    extraRaw = 15'h0000;
    intakeSet = 16'h0190;
    cyc(8);
    srst = 1'h0;
    cyc(2);
    t_reset();
    t_displays();
    t_adjust();
    t_hold();
    t_preset();
    t_mode();
    t_idle();
    end_of_test();
  end
endmodule
`default_nettype wire
